// ==== rtl/data_memory_system_io_bank.sv ====
`timescale 1ns/1ns
module data_memory_system_io_bank (
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    input  wire logic [15:0] mem_addr,
    input  wire logic        mem_rd,
    input  wire logic        mem_wr,
    input  wire logic        mem_wide,
    input  wire logic [15:0] mem_wdata,
    output logic      [15:0] mem_rdata,
    input  wire logic [3:0]  key_group0_pins,
    input  wire logic [3:0]  key_group1_pins,
    input  wire logic        key_group2_pin,
    input  wire logic        detect_low_pin,
    input  wire logic        freq_out_pin,
    input  wire logic        timer_out_pin,
    input  wire logic        timer_out_enable,
    output logic             cpu_clock_select,
    output logic             fast_oscillator_on,
    output logic      [3:0]  detect_threshold_field,
    output logic             detector_on,
    output logic             freq_out_enable,
    output logic      [1:0]  freq_out_sel,
    output logic             watchdog_enable_bit,
    output logic             watchdog_restart,
    output logic      [8:0]  key_irq_enable,
    output logic      [8:0]  key_compare,
    output logic             key_sense_on,
    output logic      [3:0]  r0_out,
    output logic      [3:0]  r0_oe_n,
    output logic      [3:0]  r1_out,
    output logic      [3:0]  r1_oe_n
);
    import io_bank_pkg::*;

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    logic [3:0] cpu_clk_r;
    logic [3:0] legacy_r;
    logic [3:0] det_level_r;
    logic       det_on_r;
    logic       det_low_r;
    logic [3:0] freq_r;
    logic       wd_en_r;
    logic       wd_restart_r;
    logic [3:0] k0_irq_r;
    logic [3:0] k1_irq_r;
    logic       k2_irq_r;
    logic [3:0] k0_cmp_r;
    logic [3:0] k1_cmp_r;
    logic       k2_cmp_r;
    logic       sense_r;
    logic [3:0] r0_hiz_r;
    logic [3:0] r0_data_r;
    logic       r1_hiz_r;
    logic [3:0] r1_data_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [9:0] sync1_r;
    logic [9:0] sync2_r;
    logic [3:0] r0_out_r;
    logic [3:0] r0_oe_n_r;
    logic [3:0] r1_out_r;
    logic [3:0] r1_oe_n_r;

    logic       in_ram;
    logic       in_wide;
    logic       in_disp;
    logic       acc_ok;
    logic       wr_io;
    logic [3:0] wd;

    store_if st ();

    data_store #(
        .RAM_N  (RAM_WORDS),
        .DISP_N (DISP_WORDS)
    ) u_store (
        .sys_clk (sys_clk),
        .ce      (ce),
        .bus     (st)
    );

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    assign in_ram  = mem_addr <= RAM_LAST;
    assign in_wide = mem_addr >= WIDE_FIRST
                  && mem_addr <= WIDE_LAST;
    assign in_disp = mem_addr >= DISP_FIRST
                  && mem_addr <= DISP_LAST;
    // Wide access outside its window is dropped
    assign acc_ok  = !mem_wide || in_wide;
    assign wr_io   = mem_wr && !mem_wide;
    assign wd      = mem_wdata[3:0];

    assign st.ram_idx  = mem_addr[10:0];
    assign st.disp_idx = mem_addr[4:0];
    assign st.wide     = mem_wide;
    assign st.wdata    = mem_wdata;
    assign st.ram_we   = mem_wr && in_ram && acc_ok;
    assign st.disp_we  = wr_io && in_disp;

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (ce) begin
            sync1_r <= {detect_low_pin, key_group2_pin,
                        key_group1_pins, key_group0_pins};
            sync2_r <= sync1_r;
        end
    end

    // ---------------------------------------------------------------
    // Clock and legacy power control
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cpu_clk_r <= RST_ZERO4;
            legacy_r  <= RST_ZERO4;
        end else if (ce && wr_io) begin
            if (mem_addr == A_CPU_CLK) begin
                cpu_clk_r <= {wd[3:2], 1'b0, wd[0]};
            end
            if (mem_addr == A_LEGACY) begin
                // Stored only, no effect on supply or mode
                legacy_r <= {wd[3:2], 1'b0, wd[0]};
            end
        end
    end

    // ---------------------------------------------------------------
    // Supply voltage detector
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            det_level_r <= RST_ZERO4;
            det_on_r    <= 1'b0;
        end else if (ce && wr_io) begin
            if (mem_addr == A_DET_LEVEL) begin
                det_level_r <= wd;
            end
            if (mem_addr == A_DET_CTRL) begin
                det_on_r <= wd[B_DET_ON];
            end
        end
    end

    // Result follows the comparator only while the detector runs
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            det_low_r <= 1'b0;
        end else if (ce && det_on_r) begin
            det_low_r <= sync2_r[9];
        end
    end

    // ---------------------------------------------------------------
    // Frequency output and watchdog
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            freq_r <= RST_ZERO4;
        end else if (ce && wr_io && mem_addr == A_FREQ_OUT) begin
            freq_r <= {wd[3], 1'b0, wd[1:0]};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            wd_en_r      <= RST_WD_EN;
            wd_restart_r <= 1'b0;
        end else if (ce) begin
            wd_restart_r <= 1'b0;
            if (wr_io && mem_addr == A_WATCHDOG) begin
                wd_en_r      <= wd[B_WD_EN];
                wd_restart_r <= wd[B_WD_RESTART];
            end
        end
    end

    // ---------------------------------------------------------------
    // Key input control
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            k0_irq_r <= RST_ZERO4;
            k1_irq_r <= RST_ZERO4;
            k2_irq_r <= 1'b0;
        end else if (ce && wr_io) begin
            if (mem_addr == A_K0_IRQ) begin
                k0_irq_r <= wd;
            end
            if (mem_addr == A_K1_IRQ) begin
                k1_irq_r <= wd;
            end
            if (mem_addr == A_K2_IRQ) begin
                k2_irq_r <= wd[0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            k0_cmp_r <= RST_K0_CMP;
            k1_cmp_r <= RST_K1_CMP;
            k2_cmp_r <= RST_K2_CMP;
            sense_r  <= RST_SENSE;
        end else if (ce && wr_io) begin
            if (mem_addr == A_K0_CMP) begin
                k0_cmp_r <= wd;
            end
            if (mem_addr == A_K1_CMP) begin
                k1_cmp_r <= wd;
            end
            if (mem_addr == A_K2_CMP) begin
                k2_cmp_r <= wd[0];
            end
            if (mem_addr == A_SENSE) begin
                sense_r <= wd[0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Output ports
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r0_hiz_r  <= RST_ZERO4;
            r0_data_r <= RST_OUT_DATA;
            r1_hiz_r  <= 1'b0;
            r1_data_r <= RST_OUT_DATA;
        end else if (ce && wr_io) begin
            if (mem_addr == A_R0_HIZ) begin
                r0_hiz_r <= wd;
            end
            if (mem_addr == A_R0_DATA) begin
                r0_data_r <= wd;
            end
            if (mem_addr == A_R1_HIZ) begin
                r1_hiz_r <= wd[0];
            end
            if (mem_addr == A_R1_DATA) begin
                r1_data_r <= wd;
            end
        end
    end

    // Shared pins carry the special signal while it is selected
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            r0_out_r  <= RST_OUT_DATA;
            r0_oe_n_r <= RST_ZERO4;
            r1_out_r  <= RST_OUT_DATA;
            r1_oe_n_r <= RST_ZERO4;
        end else if (ce) begin
            r0_out_r <= r0_data_r;
            if (freq_r[B_FREQ_OUT_PIN_EN]) begin
                // Data bit is expected to stay at one here
                r0_out_r[B_OUT3] <= freq_out_pin;
            end
            if (timer_out_enable) begin
                r0_out_r[B_OUT2] <= timer_out_pin;
            end
            r0_oe_n_r <= r0_hiz_r;
            r1_out_r  <= r1_data_r;
            r1_oe_n_r <= {4{r1_hiz_r}};
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    always_comb begin
        rdata_nxt = 16'h0000;
        if (in_ram) begin
            if (acc_ok) begin
                rdata_nxt = st.ram_rdata;
            end
        end else if (mem_wide) begin
            rdata_nxt = 16'h0000;
        end else if (in_disp) begin
            rdata_nxt[3:0] = st.disp_rdata;
        end else begin
            unique case (mem_addr)
                A_CPU_CLK:   rdata_nxt[3:0] = cpu_clk_r;
                A_LEGACY:    rdata_nxt[3:0] = legacy_r;
                A_DET_LEVEL: rdata_nxt[3:0] = det_level_r;
                A_DET_CTRL:  rdata_nxt[3:0] = {2'b00, det_low_r,
                                               det_on_r};
                A_FREQ_OUT:  rdata_nxt[3:0] = freq_r;
                A_WATCHDOG:  rdata_nxt[3:0] = {2'b00, wd_en_r,
                                               1'b0};
                A_K0_IRQ:    rdata_nxt[3:0] = k0_irq_r;
                A_K0_IN:     rdata_nxt[3:0] = sync2_r[3:0];
                A_K0_CMP:    rdata_nxt[3:0] = k0_cmp_r;
                A_K1_IRQ:    rdata_nxt[3:0] = k1_irq_r;
                A_K1_IN:     rdata_nxt[3:0] = sync2_r[7:4];
                A_K1_CMP:    rdata_nxt[3:0] = k1_cmp_r;
                A_K2_IRQ:    rdata_nxt[3:0] = {3'b000, k2_irq_r};
                A_K2_IN:     rdata_nxt[3:0] = {3'b000,
                                               sync2_r[8]};
                A_K2_CMP:    rdata_nxt[3:0] = {3'b000, k2_cmp_r};
                A_SENSE:     rdata_nxt[3:0] = {3'b000,
                                               sense_r};
                A_R0_HIZ:    rdata_nxt[3:0] = r0_hiz_r;
                A_R0_DATA:   rdata_nxt[3:0] = r0_data_r;
                A_R1_HIZ:    rdata_nxt[3:0] = {3'b000,
                                               r1_hiz_r};
                A_R1_DATA:   rdata_nxt[3:0] = r1_data_r;
                default:     rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
        end else if (ce && mem_rd) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign mem_rdata              = rdata_r;
    assign cpu_clock_select       = cpu_clk_r[B_CLK_SEL];
    assign fast_oscillator_on     = cpu_clk_r[B_FAST_ON];
    assign detect_threshold_field = det_level_r;
    assign detector_on            = det_on_r;
    assign freq_out_enable        = freq_r[B_FREQ_OUT_PIN_EN];
    assign freq_out_sel           = freq_r[1:0];
    assign watchdog_enable_bit    = wd_en_r;
    assign watchdog_restart       = wd_restart_r;
    assign key_irq_enable         = {k2_irq_r, k1_irq_r, k0_irq_r};
    assign key_compare            = {k2_cmp_r, k1_cmp_r, k0_cmp_r};
    assign key_sense_on           = sense_r;
    assign r0_out                 = r0_out_r;
    assign r0_oe_n                = r0_oe_n_r;
    assign r1_out                 = r1_out_r;
    assign r1_oe_n                = r1_oe_n_r;
endmodule // data_memory_system_io_bank

// ==== inc/io_bank_pkg.sv ====
package io_bank_pkg;

// ---------------------------------------------------------------
// Data memory layout
// ---------------------------------------------------------------
localparam logic [15:0] RAM_FIRST   = 16'h0000;
localparam logic [15:0] RAM_LAST    = 16'h07FF;
localparam logic [15:0] WIDE_FIRST  = 16'h0100;
localparam logic [15:0] WIDE_LAST   = 16'h01FF;
localparam logic [15:0] DISP_FIRST  = 16'hF000;
localparam logic [15:0] DISP_LAST   = 16'hF01F;
localparam int          RAM_WORDS   = 2048;
localparam int          DISP_WORDS  = 32;
localparam int          IO_WORDS    = 76;

// ---------------------------------------------------------------
// Peripheral register addresses
// ---------------------------------------------------------------
localparam logic [15:0] A_CPU_CLK   = 16'hFF00;
localparam logic [15:0] A_LEGACY    = 16'hFF01;
localparam logic [15:0] A_DET_LEVEL = 16'hFF04;
localparam logic [15:0] A_DET_CTRL  = 16'hFF05;
localparam logic [15:0] A_FREQ_OUT  = 16'hFF06;
localparam logic [15:0] A_WATCHDOG  = 16'hFF07;
localparam logic [15:0] A_K0_IRQ    = 16'hFF20;
localparam logic [15:0] A_K0_IN     = 16'hFF21;
localparam logic [15:0] A_K0_CMP    = 16'hFF22;
localparam logic [15:0] A_K1_IRQ    = 16'hFF24;
localparam logic [15:0] A_K1_IN     = 16'hFF25;
localparam logic [15:0] A_K1_CMP    = 16'hFF26;
localparam logic [15:0] A_K2_IRQ    = 16'hFF28;
localparam logic [15:0] A_K2_IN     = 16'hFF29;
localparam logic [15:0] A_K2_CMP    = 16'hFF2A;
localparam logic [15:0] A_SENSE     = 16'hFF2B;
localparam logic [15:0] A_R0_HIZ    = 16'hFF30;
localparam logic [15:0] A_R0_DATA   = 16'hFF31;
localparam logic [15:0] A_R1_HIZ    = 16'hFF32;
localparam logic [15:0] A_R1_DATA   = 16'hFF33;

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
localparam int B_CLK_SEL    = 3;
localparam int B_FAST_ON    = 2;
localparam int B_REG_LEVEL  = 0;
localparam int B_DET_LOW    = 1;
localparam int B_DET_ON     = 0;
localparam int B_FREQ_OUT_PIN_EN    = 3;
localparam int B_WD_EN      = 1;
localparam int B_WD_RESTART = 0;
localparam int B_OUT3       = 3;
localparam int B_OUT2       = 2;

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
localparam logic [3:0] RST_ZERO4    = 4'h0;
localparam logic [3:0] RST_K0_CMP   = 4'hE;
localparam logic [3:0] RST_K1_CMP   = 4'hF;
localparam logic       RST_K2_CMP   = 1'b1;
localparam logic       RST_SENSE    = 1'b1;
localparam logic       RST_WD_EN    = 1'b1;
localparam logic [3:0] RST_OUT_DATA = 4'hF;

endpackage

// ==== inc/store_if.sv ====
`timescale 1ns/1ns
interface store_if;
    logic [10:0] ram_idx;
    logic [4:0]  disp_idx;
    logic        ram_we;
    logic        disp_we;
    logic        wide;
    logic [15:0] wdata;
    logic [15:0] ram_rdata;
    logic [3:0]  disp_rdata;

    modport ctrl (
        output ram_idx, disp_idx, ram_we, disp_we, wide, wdata,
        input  ram_rdata, disp_rdata
    );
    modport store (
        input  ram_idx, disp_idx, ram_we, disp_we, wide, wdata,
        output ram_rdata, disp_rdata
    );
endinterface : store_if

// ==== rtl/data_store.sv ====
`timescale 1ns/1ns
module data_store #(
    parameter int RAM_N  = 2048,
    parameter int DISP_N = 32
) (
    input  wire logic  sys_clk,
    input  wire logic  ce,
    store_if.store     bus
);
    import io_bank_pkg::*;

    logic [3:0] ram_mem  [RAM_N];
    logic [3:0] disp_mem [DISP_N];
    logic [10:0] base;

    // Wide words are four nibbles from an index aligned to four
    assign base = {bus.ram_idx[10:2], 2'b00};

    // ---------------------------------------------------------------
    // Writes
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (ce && bus.ram_we) begin
            if (bus.wide) begin
                for (int i = 0; i < 4; i++) begin
                    ram_mem[base + 11'(i)] <= bus.wdata[i*4 +: 4];
                end
            end else begin
                ram_mem[bus.ram_idx] <= bus.wdata[3:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (ce && bus.disp_we) begin
            disp_mem[bus.disp_idx] <= bus.wdata[3:0];
        end
    end

    // ---------------------------------------------------------------
    // Reads
    // ---------------------------------------------------------------
    always_comb begin
        if (bus.wide) begin
            for (int i = 0; i < 4; i++) begin
                bus.ram_rdata[i*4 +: 4] = ram_mem[base + 11'(i)];
            end
        end else begin
            bus.ram_rdata = {12'h000, ram_mem[bus.ram_idx]};
        end
    end

    assign bus.disp_rdata = disp_mem[bus.disp_idx];
endmodule // data_store

// ==== sim/io_bank_assertions.sv ====
`timescale 1ns/1ns
module io_bank_assertions (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic        ce,
    input wire logic [15:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic        mem_wide,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic        freq_out_pin,
    input wire logic        timer_out_pin,
    input wire logic        timer_out_enable,
    input wire logic        cpu_clock_select,
    input wire logic        fast_oscillator_on,
    input wire logic        freq_out_enable,
    input wire logic        watchdog_restart,
    input wire logic [8:0]  key_irq_enable,
    input wire logic [3:0]  r0_out,
    input wire logic [3:0]  r1_out,
    input wire logic [3:0]  r1_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----
    // Nibble accesses and the stored value two edges on
    // ----
    sequence wr_at(a);
        ce && mem_wr && !mem_wide && mem_addr == a;
    endsequence
    sequence rd_at(a);
        ce && mem_rd && !mem_wide && mem_addr == a;
    endsequence
    property p_store(a, v, w);
        wr_at(a) ##1 (ce && !(mem_wr && mem_addr == a)) |-> ##1 v == w;
    endproperty
    a_clk_bits_store: assert property (p_store(16'hFF00,
        {cpu_clock_select, fast_oscillator_on}, $past(mem_wdata[3:2], 2)))
        else $error("clock control bits not stored");
    a_irq_sel_store: assert property (p_store(16'hFF20,
        key_irq_enable[3:0], $past(mem_wdata[3:0], 2)))
        else $error("key irq select not stored");
    a_r1_data_pins: assert property (p_store(16'hFF33,
        r1_out, $past(mem_wdata[3:0], 2)))
        else $error("group one pins do not follow data");
    a_r1_hiz_pins: assert property (p_store(16'hFF32,
        r1_oe_n, {4{$past(mem_wdata[0], 2)}}))
        else $error("group one enables do not follow control");
    a_restart_pulse: assert property (wr_at(16'hFF07) ##0 mem_wdata[0]
        |=> watchdog_restart) else $error("restart pulse missing");
    a_restart_cause: assert property (watchdog_restart |-> $past(ce
        && mem_wr && !mem_wide && mem_wdata[0] && mem_addr == 16'hFF07))
        else $error("restart pulse without write");
    a_wide_read_zero: assert property (ce && mem_rd && mem_wide
        && (mem_addr < 16'h0100 || mem_addr > 16'h01FF)
        |=> mem_rdata == 16'h0000) else $error("wide read outside area");
    a_result_bits_zero: assert property (rd_at(16'hFF05)
        |=> mem_rdata[15:2] == 14'h0) else $error("unused bits not zero");
    a_freq_out_mux: assert property ($past(rst_n) && $past(ce)
        && $past(freq_out_enable) |-> r0_out[3] == $past(freq_out_pin))
        else $error("frequency output not routed");
    a_timer_out_mux: assert property ($past(rst_n) && $past(ce)
        && $past(timer_out_enable) |-> r0_out[2] == $past(timer_out_pin))
        else $error("timer output not routed");
endmodule // io_bank_assertions
bind data_memory_system_io_bank io_bank_assertions chk_u (.*);

// ==== sim/cpu_bus_model.sv ====
`timescale 1ns/1ns
module cpu_bus_model (
    input  wire logic        sys_clk,
    input  wire logic [15:0] mem_rdata,
    output logic      [15:0] mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic             mem_wide,
    output logic      [15:0] mem_wdata
);
    initial begin
        mem_addr = 16'h5A5A;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        mem_wide = 1'b0;
        mem_wdata = 16'hA5A5;
    end
    // ----
    // One access held over its taking edge, then address scrambled
    // ----
    task automatic access(input int gap, input logic [15:0] a,
                          input logic w, input logic rd,
                          input logic [15:0] d, output logic [15:0] q);
        repeat (gap) @(posedge sys_clk);
        mem_addr <= a;
        mem_wide <= w;
        mem_rd <= rd;
        mem_wr <= !rd;
        mem_wdata <= d;
        @(posedge sys_clk);
        mem_rd <= 1'b0;
        mem_wr <= 1'b0;
        mem_addr <= ~a;
        mem_wdata <= ~d;
        @(posedge sys_clk);
        q = mem_rdata;
    endtask
endmodule // cpu_bus_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import io_bank_pkg::*;
    logic        sys_clk, rst_n, ce, mem_rd, mem_wr, mem_wide, det;
    logic [15:0] mem_addr, mem_wdata, mem_rdata, q;
    logic [3:0]  key_group0_pins, key_group1_pins, r0_out, r0_oe_n, d;
    logic [3:0]  r1_out, r1_oe_n, detect_threshold_field;
    logic        key_group2_pin, detect_low_pin, freq_out_pin;
    logic        timer_out_pin, timer_out_enable, cpu_clock_select;
    logic        fast_oscillator_on, detector_on, freq_out_enable;
    logic        watchdog_enable_bit, watchdog_restart, key_sense_on;
    logic [1:0]  freq_out_sel;
    logic [8:0]  key_irq_enable, key_compare;
    int          error_cnt = 0, comparisons = 0, cyc = 0, i, j;
    logic [15:0] ra [17] = '{16'hFF00, 16'hFF01, 16'hFF04, 16'hFF05,
        16'hFF06, 16'hFF07, 16'hFF20, 16'hFF22, 16'hFF24, 16'hFF26,
        16'hFF28, 16'hFF2A, 16'hFF2B, 16'hFF30, 16'hFF31, 16'hFF32,
        16'hFF33};
    logic [3:0]  rm [17] = '{4'hD, 4'hD, 4'hF, 4'h1, 4'hB, 4'h2, 4'hF,
        4'hF, 4'hF, 4'hF, 4'h1, 4'h1, 4'h1, 4'hF, 4'hF, 4'h1, 4'hF};
    logic [3:0]  rr [17] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2, 4'h0,
        4'hE, 4'h0, 4'hF, 4'h0, 4'h1, 4'h1, 4'h0, 4'hF, 4'h0, 4'hF};
    logic [3:0]  mdl [17];
    data_memory_system_io_bank dut_u (.*);
    cpu_bus_model cpu_u (.*);
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        freq_out_pin <= 1'($urandom);
        timer_out_pin <= 1'($urandom);
        timer_out_enable <= 1'($urandom);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end
    // ----
    // Checking and bus helpers
    // ----
    task automatic check(logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(logic [15:0] a, logic w, logic [15:0] v);
        cpu_u.access($urandom % 3, a, w, 1'b0, v, q);
    endtask
    task automatic rdc(logic [15:0] a, logic w, logic [15:0] e);
        cpu_u.access($urandom % 3, a, w, 1'b1, 16'h0000, q);
        check({16'h0000, q}, {16'h0000, e});
    endtask
    function automatic logic [15:0] want(int k);
        want = {12'h000, mdl[k]};
        if (k == 3) want[1] = det;
    endfunction
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        mdl = rr;
        det = 1'b0;
        for (int k = 0; k < 17; k++) begin
            rdc(ra[k], 1'b0, want(k));
        end
        $display("reset value test done");
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        detect_low_pin = 1'b1;
        {key_group2_pin, key_group1_pins, key_group0_pins} = 9'h000;
        {freq_out_pin, timer_out_pin, timer_out_enable} = 3'h0;
        void'($urandom(87));
        do_reset();
        wr(16'h0100, 1'b1, 16'hA5C3);
        rdc(16'h0100, 1'b1, 16'hA5C3);
        rdc(16'h0102, 1'b0, 16'h0005);
        wr(16'h0200, 1'b0, 16'h0007);
        wr(16'h0200, 1'b1, 16'hFFFF);
        rdc(16'h0200, 1'b0, 16'h0007);
        rdc(16'hFF00, 1'b1, 16'h0000);
        wr(16'h07FF, 1'b0, 16'h0009);
        rdc(16'h07FF, 1'b0, 16'h0009);
        wr(16'h0800, 1'b0, 16'h0009);
        rdc(16'h0800, 1'b0, 16'h0000);
        wr(16'hF01F, 1'b0, 16'h000A);
        rdc(16'hF01F, 1'b0, 16'h000A);
        wr(16'hFF02, 1'b0, 16'h000F);
        rdc(16'hFF02, 1'b0, 16'h0000);
        wr(16'hFF07, 1'b0, 16'h0001);
        mdl[5] = 4'h0;
        rdc(16'hFF07, 1'b0, 16'h0000);
        ce <= 1'b0;
        wr(16'hFF04, 1'b0, 16'h0009);
        ce <= 1'b1;
        rdc(16'hFF04, 1'b0, 16'h0000);
        $display("decode test done");
        for (int n = 0; n < 4; n++) begin
            {detect_low_pin, key_group2_pin, key_group1_pins,
             key_group0_pins} <= 10'($urandom);
            repeat (3) @(posedge sys_clk);
            wr(16'hFF21, 1'b0, {12'h000, ~key_group0_pins});
            rdc(16'hFF21, 1'b0, {12'h000, key_group0_pins});
            rdc(16'hFF25, 1'b0, {12'h000, key_group1_pins});
            rdc(16'hFF29, 1'b0, {15'h0000, key_group2_pin});
        end
        $display("key input test done");
        for (int n = 0; n < 80; n++) begin
            i = $urandom % 17;
            d = 4'($urandom);
            if (i == 14) d[3:2] = 2'b11;
            wr(ra[i], 1'b0, {12'h000, d});
            mdl[i] = d & rm[i];
            if (i == 3 && d[0]) det = detect_low_pin;
            j = $urandom % 17;
            rdc(ra[j], 1'b0, want(j));
        end
        check({16'h0000, r0_oe_n, r1_oe_n, r1_out, 2'b00, r0_out[1:0]},
            {16'h0000, mdl[13], {4{mdl[15][0]}}, mdl[16], 2'b00, mdl[14][1:0]});
        check({2'b00, cpu_clock_select, fast_oscillator_on, detector_on,
            freq_out_enable, freq_out_sel, watchdog_enable_bit, key_sense_on,
            detect_threshold_field, key_irq_enable, key_compare},
            {2'b00, mdl[0][3:2], mdl[3][0], mdl[4][3], mdl[4][1:0], mdl[5][1],
            mdl[12][0], mdl[2], mdl[10][0], mdl[8], mdl[6], mdl[11][0],
            mdl[9], mdl[7]});
        $display("random register test done");
        do_reset();
        summarize();
    end
endmodule // testbench
